// ==== ulf_line_format.sv ====
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "ulf_defines.svh"
module ulf_line_format
	import ulf_pkg::*;
#(
	parameter int CLKS_PER_BIT = 16 // bit time in clocks
)(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	output logic             txd,
	input  wire logic        rxd
);
	localparam int HALF = CLKS_PER_BIT / 2;

	// ==========================================
	// reset release
	logic rst_m;  // first reset stage
	logic rst_sb; // released reset copy

	// async assert, two-stage release
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_m  <= 1'b0;
			rst_sb <= 1'b0;
		end
		else
		begin
			rst_m  <= 1'b1;
			rst_sb <= rst_m;
		end
	end

	// ==========================================
	// state
	typedef struct packed {
		logic [6:0]  line;   // format register
		logic [1:0]  flush;  // flush countdown
		logic [7:0]  thr;    // holding byte
		logic        thr_f;  // holding full
		ulf_tx_e     tst;    // tx state
		logic [15:0] tcnt;   // tx clock count
		logic [2:0]  tbit;   // tx bit index
		logic [7:0]  tsh;    // tx shifter
		logic        tpar;   // tx parity bit
		logic        tline;  // sequencer line
		logic        txd;    // pin flop
		logic        rs0;    // rx sync 1
		logic        rs1;    // rx sync 2
		ulf_rx_e     rst;    // rx state
		logic [15:0] rcnt;   // rx clock count
		logic [2:0]  rbit;   // rx bit index
		logic [7:0]  rsh;    // rx shifter
		logic        rpar;   // sampled parity
		logic [7:0]  rdat;   // received byte
		logic        rval;   // byte ready
		logic        perr;   // parity error
		logic        ferr;   // framing error
		logic [31:0] rdata;  // read data
	} ulf_state_s;

	ulf_state_s s;      // current
	ulf_state_s next_s; // next

	// ==========================================
	// format decode
	logic [3:0]  nbits;    // data bits
	logic        pen;      // parity on
	logic [15:0] stop_len; // stop period
	logic [7:0]  dmask;    // valid data bits

	always_comb
	begin
		// five plus length field
		nbits = `ULF_MIN_LEN + {2'h0, s.line[`ULF_LEN_LSB +: 2]};
		pen   = s.line[`ULF_PEN_BIT];
		dmask = 8'hFF >> (4'h8 - nbits);
		if (!s.line[`ULF_STOP_BIT])
			stop_len = 16'(CLKS_PER_BIT);
		else if (s.line[1:0] == 2'h0)
			stop_len = 16'(CLKS_PER_BIT + HALF);
		else
			stop_len = 16'(2 * CLKS_PER_BIT);
	end

	// parity for a data byte
	function automatic logic par_of(input logic [7:0] d, input logic [6:0] l);
		logic even;
		even = l[`ULF_EVEN_BIT];
		// stick: odd select sends 1, even sends 0
		if (l[`ULF_STICK_BIT])
			par_of = ~even;
		else
			par_of = even ? ^d : ~^d;
	endfunction : par_of

	// ==========================================
	// next state
	always_comb
	begin
		next_s = s;
		next_s.rs0 = rxd;
		next_s.rs1 = s.rs0;

		// register writes
		if (wr && addr == `ULF_OFS_LINE)
			next_s.line = wdata[`ULF_LINE_W-1:0];
		// a full holding byte refuses new data
		if (wr && addr == `ULF_OFS_DATA && !s.thr_f)
		begin
			next_s.thr   = wdata[7:0];
			next_s.thr_f = 1'b1;
		end

		// ---- transmitter ----
		next_s.tcnt = s.tcnt + 16'h1;
		unique case (s.tst)
			TX_IDLE:
			begin
				next_s.tline = 1'b1;
				next_s.tcnt  = 16'h0;
				if (s.thr_f)
				begin
					next_s.tsh   = s.thr & dmask;
					next_s.tpar  = par_of(s.thr & dmask, s.line);
					next_s.thr_f = 1'b0;
					next_s.tst   = TX_START;
					next_s.tline = 1'b0;
				end
			end
			TX_START:
			begin
				if (s.tcnt == 16'(CLKS_PER_BIT - 1))
				begin
					next_s.tcnt  = 16'h0;
					next_s.tbit  = 3'h0;
					next_s.tst   = TX_DATA;
					next_s.tline = s.tsh[0]; // lsb first
				end
			end
			TX_DATA:
			begin
				if (s.tcnt == 16'(CLKS_PER_BIT - 1))
				begin
					next_s.tcnt = 16'h0;
					next_s.tsh  = s.tsh >> 1;
					next_s.tbit = s.tbit + 3'h1;
					if ({1'b0, s.tbit} == nbits - 4'h1)
					begin
						// parity slot right after last bit
						next_s.tst   = pen ? TX_PAR : TX_STOP;
						next_s.tline = pen ? s.tpar : 1'b1;
					end
					else
						next_s.tline = s.tsh[1];
				end
			end
			TX_PAR:
			begin
				if (s.tcnt == 16'(CLKS_PER_BIT - 1))
				begin
					next_s.tcnt  = 16'h0;
					next_s.tst   = TX_STOP;
					next_s.tline = 1'b1;
				end
			end
			TX_STOP:
			begin
				// stop length follows format
				if (s.tcnt >= stop_len - 16'h1)
				begin
					next_s.tcnt = 16'h0;
					next_s.tst  = TX_IDLE;
				end
			end
		endcase

		// flush request, self-clears after three cycles
		if (s.flush != 2'h0)
			next_s.flush = s.flush - 2'h1;
		if (wr && addr == `ULF_OFS_QCTL && wdata[`ULF_FLUSH_BIT])
			next_s.flush = `ULF_FLUSH_CYC;
		if (s.flush != 2'h0 || next_s.flush != 2'h0)
		begin
			next_s.thr_f = 1'b0;
			next_s.tst   = TX_IDLE;
			next_s.tcnt  = 16'h0;
			next_s.tline = 1'b1;
		end

		// break only gates the pin
		next_s.txd = next_s.tline & ~next_s.line[`ULF_BRK_BIT];

		// ---- receiver ----
		if (rd && addr == `ULF_OFS_DATA)
			next_s.rval = 1'b0; // read clears, set below wins
		next_s.rcnt = s.rcnt + 16'h1;
		unique case (s.rst)
			RX_IDLE:
			begin
				next_s.rcnt = 16'h0;
				if (!s.rs1)
					next_s.rst = RX_START;
			end
			RX_START:
			begin
				// recheck start at mid bit
				if (s.rcnt == 16'(HALF - 1))
				begin
					next_s.rcnt = 16'h0;
					next_s.rbit = 3'h0;
					next_s.rst  = s.rs1 ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA:
			begin
				if (s.rcnt == 16'(CLKS_PER_BIT - 1))
				begin
					next_s.rcnt = 16'h0;
					next_s.rsh  = {s.rs1, s.rsh[7:1]}; // lsb first
					next_s.rbit = s.rbit + 3'h1;
					if ({1'b0, s.rbit} == nbits - 4'h1)
						next_s.rst = pen ? RX_PAR : RX_STOP;
				end
			end
			RX_PAR:
			begin
				if (s.rcnt == 16'(CLKS_PER_BIT - 1))
				begin
					next_s.rcnt = 16'h0;
					next_s.rpar = s.rs1;
					next_s.rst  = RX_STOP;
				end
			end
			RX_STOP:
			begin
				if (s.rcnt == 16'(CLKS_PER_BIT - 1))
				begin
					next_s.rdat = s.rsh >> (4'h8 - nbits);
					next_s.rval = 1'b1;
					// check only with parity on
					next_s.perr = pen && (s.rpar != par_of(s.rsh >> (4'h8 - nbits), s.line));
					next_s.ferr = ~s.rs1;
					next_s.rst  = RX_IDLE;
				end
			end
		endcase

		// read mux, one cycle later
		next_s.rdata = 32'h0;
		if (rd)
		begin
			unique case (addr)
				`ULF_OFS_DATA: next_s.rdata = {24'h0, s.rdat};
				`ULF_OFS_QCTL: next_s.rdata = {29'h0, s.flush != 2'h0, 2'h0};
				`ULF_OFS_LINE: next_s.rdata = {25'h0, s.line};
				`ULF_OFS_STAT: next_s.rdata = {27'h0, s.ferr, s.perr, s.rval,
				                               s.thr_f, s.tst != TX_IDLE};
				default:       next_s.rdata = 32'h0; // unmapped
			endcase
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge clk or negedge rst_sb)
	begin
		if (!rst_sb)
		begin
			s       <= '0;
			s.line  <= `ULF_LINE_RST;
			s.tst   <= TX_IDLE;
			s.rst   <= RX_IDLE;
			s.tline <= 1'b1;
			s.txd   <= 1'b1;
			s.rs0   <= 1'b1;
			s.rs1   <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign rdata = s.rdata;
	assign txd   = s.txd;

	// ==========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sb);

	AST_BREAK_LOW: assert property (s.line[`ULF_BRK_BIT] |-> !txd)
		else $error("break set but pin high");
	AST_BREAK_SEQ: assert property (s.line[`ULF_BRK_BIT] && s.tst == TX_START
		&& s.tcnt == 16'(CLKS_PER_BIT - 1) |=> s.tst == TX_DATA)
		else $error("break stalled sequencer");
	AST_STICK_ONE: assert property (s.tst == TX_PAR && s.line[5:3] == 3'b101
		|-> s.tline)
		else $error("stick parity not one");
	AST_STICK_ZERO: assert property (s.tst == TX_PAR && s.line[5:3] == 3'b111
		|-> !s.tline)
		else $error("stick parity not zero");
	AST_EVEN: assert property (s.tst == TX_START && s.line[5:3] == 3'b011
		|-> s.tpar == ^s.tsh)
		else $error("even parity wrong");
	AST_ODD: assert property (s.tst == TX_START && s.line[5:3] == 3'b001
		|-> s.tpar == ~^s.tsh)
		else $error("odd parity wrong");
	AST_NO_PAR: assert property (!pen |-> s.tst != TX_PAR && s.rst != RX_PAR)
		else $error("parity slot without parity");
	AST_ONE_STOP: assert property (s.tst == TX_STOP && !s.line[`ULF_STOP_BIT]
		|-> s.tcnt < 16'(CLKS_PER_BIT))
		else $error("stop too long");
	AST_FLUSH: assert property (wr && addr == `ULF_OFS_QCTL && wdata[`ULF_FLUSH_BIT]
		|=> s.flush == 2'h3 ##1 s.flush == 2'h2 ##1 s.flush == 2'h1
		##1 s.flush == 2'h0)
		else $error("flush timing wrong");
	// a queued byte launches its start bit next cycle, and a break may be written meanwhile
	AST_IDLE_MARK: assert property (s.tst == TX_IDLE && s.flush == 2'h0 && !s.thr_f
		&& !s.line[`ULF_BRK_BIT] |=> txd || s.line[`ULF_BRK_BIT])
		else $error("idle line not mark");
	AST_RSVD: assert property ($past(rd) && $past(addr) == `ULF_OFS_LINE |-> rdata[31:7] == 25'h0)
		else $error("reserved bits set");

	COV_PAR: cover property (s.tst == TX_PAR);
	COV_HALF: cover property (s.tst == TX_STOP && s.line[2:0] == 3'b100);
	COV_RX: cover property (s.rst == RX_STOP ##1 s.rval);
	COV_BRK: cover property (s.line[`ULF_BRK_BIT] && s.tst == TX_DATA);
endmodule : ulf_line_format

// ==== ulf_defines.svh ====
`ifndef ULF_DEFINES_SVH
`define ULF_DEFINES_SVH
// ==========================================
// register byte offsets
`define ULF_OFS_DATA   8'h00
`define ULF_OFS_QCTL   8'h08
`define ULF_OFS_LINE   8'h0C
`define ULF_OFS_STAT   8'h1C
// ==========================================
// line format fields
`define ULF_LINE_W     7
`define ULF_LINE_RST   7'h00
`define ULF_LEN_LSB    0
`define ULF_STOP_BIT   2
`define ULF_PEN_BIT    3
`define ULF_EVEN_BIT   4
`define ULF_STICK_BIT  5
`define ULF_BRK_BIT    6
// ==========================================
// queue control and timing
`define ULF_FLUSH_BIT  2
`define ULF_FLUSH_CYC  2'h3
`define ULF_MIN_LEN    4'h5
`endif

// ==== ulf_pkg.sv ====
package ulf_pkg;
	// transmit sequencer states
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulf_tx_e;
	// receive sequencer states
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ulf_rx_e;
endpackage : ulf_pkg

// ==== ulf_remote_uart.sv ====
`timescale 1ns/1ps
// ==========================================
// far-end serial port
module ulf_remote_uart #(
	parameter int CPB = 8 // clocks per bit, match dut
)(
	input  wire logic clk,
	input  wire logic txd,
	output logic      rxd
);
	time t0; // when the last start bit was seen
	initial rxd = 1'b1; // mark idle
	// start bit, then mid-bit samples
	task automatic grab(input int n, output logic [15:0] f);
		f = 16'h0;
		while (txd !== 1'b0)
			@(posedge clk);
		t0 = $time;
		repeat (CPB/2) @(posedge clk);
		f[0] = txd;
		for (int i = 1; i < n; i++)
		begin
			repeat (CPB) @(posedge clk);
			f[i] = txd;
		end
	endtask : grab
	// frame out lsb first, back to mark
	task automatic send(input logic [15:0] f, input int n);
		for (int i = 0; i < n; i++)
		begin
			rxd <= f[i];
			repeat (CPB) @(posedge clk);
		end
		rxd <= 1'b1;
	endtask : send
endmodule : ulf_remote_uart

// ==== ulf_line_format_tb.sv ====
`timescale 1ns/1ps
`include "ulf_defines.svh"
module ulf_line_format_tb;
	localparam int CPB = 8; // short even bit time
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        txd;
	logic        rxd;
	int          mismatches = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	// line settings swept by the frame
	logic [6:0]  lcs [9] = '{7'h00, 7'h04, 7'h05, 7'h12, 7'h0B, 7'h1A, 7'h2B, 7'h3B, 7'h0F};
	always #20 clk = ~clk;
	ulf_line_format #(.CLKS_PER_BIT(CPB)) u_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .txd(txd), .rxd(rxd));
	ulf_remote_uart #(.CPB(CPB)) u_far (.clk(clk), .txd(txd), .rxd(rxd));
	// ==========================================
	// plumbing
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	// hang guard, far above the expected run
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			mismatches++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// a gap cycle after each access keeps strobes from being driven twice per step
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask : rd_reg
	// expected frame: start, data lsb first, parity, first stop
	function automatic logic [15:0] fexp(input logic [6:0] lc, input logic [7:0] b, output int n);
		logic [15:0] f;
		int          nd;
		nd = 5 + lc[1:0];
		f = 16'h0;
		for (int i = 0; i < nd; i++)
			f[1+i] = b[i];
		n = 1 + nd;
		if (lc[3])
		begin
			f[n] = lc[5] ? ~lc[4] : (^(b & ~(8'hFF << nd))) ^ ~lc[4];
			n++;
		end
		f[n] = 1'b1;
		n++;
		return f;
	endfunction : fexp
	// ==========================================
	// scenarios
	task automatic t_regs;
		logic [31:0] s;
		rd_reg(`ULF_OFS_LINE, s);
		chk(s, 32'h0);
		chk({31'h0, txd}, 32'h1);
		wr_reg(`ULF_OFS_LINE, 32'hFFFFFFFF);
		rd_reg(`ULF_OFS_LINE, s);
		chk(s, 32'h7F);
		rd_reg(8'h30, s);
		chk(s, 32'h0);
		$display("register test done");
	endtask : t_regs
	// two characters back to back: bit pattern and start-to-start spacing
	task automatic t_frame(input logic [6:0] lc, input logic [7:0] b);
		logic [15:0] f1, f2, e1, e2;
		int          n, d, e;
		time         t1;
		wr_reg(`ULF_OFS_LINE, {25'h0, lc});
		e1 = fexp(lc, b, n);
		e2 = fexp(lc, ~b, n);
		e = CPB * (n - 1) + (!lc[2] ? CPB : (lc[1:0] == 2'h0 ? CPB * 3 / 2 : 2 * CPB));
		fork
		begin
			wr_reg(`ULF_OFS_DATA, {24'h0, b});
			repeat (4) @(posedge clk);
			wr_reg(`ULF_OFS_DATA, {24'h0, ~b});
		end
		begin
			u_far.grab(n, f1);
			t1 = u_far.t0;
			u_far.grab(n, f2);
		end
		join
		d = int'((u_far.t0 - t1) / 40);
		chk({16'h0, f1}, {16'h0, e1});
		chk({16'h0, f2}, {16'h0, e2});
		chk({31'h0, d >= e && d <= e + 2}, 32'h1);
		repeat (3 * CPB) @(posedge clk);
		$display("frame test %h done", lc);
	endtask : t_frame
	task automatic t_break;
		logic [31:0] s;
		int          lows;
		lows = 0;
		wr_reg(`ULF_OFS_LINE, 32'h43);
		wr_reg(`ULF_OFS_DATA, 32'h5A);
		repeat (12 * CPB)
		begin
			@(posedge clk);
			lows += int'(txd === 1'b0);
		end
		chk(lows, 12 * CPB);
		rd_reg(`ULF_OFS_STAT, s);
		chk(s & 32'h3, 32'h0);
		wr_reg(`ULF_OFS_LINE, 32'h03);
		chk({31'h0, txd}, 32'h1);
		$display("break test done");
	endtask : t_break
	// bad bit 0 breaks the parity slot, bit 1 the stop bit
	task automatic t_rx(input logic [6:0] lc, input logic [1:0] bad);
		logic [15:0] f;
		logic [31:0] s;
		int          n;
		wr_reg(`ULF_OFS_LINE, {25'h0, lc});
		f = fexp(lc, 8'h35, n);
		f[n-2] = f[n-2] ^ bad[0];
		f[n-1] = f[n-1] ^ bad[1];
		u_far.send(f, n);
		repeat (CPB) @(posedge clk);
		rd_reg(`ULF_OFS_STAT, s);
		chk(s & 32'h1C, {27'h0, bad, 3'b100});
		rd_reg(`ULF_OFS_DATA, s);
		chk(s, 32'h35);
		$display("receive test %h done", lc);
	endtask : t_rx
	task automatic t_flush;
		logic [31:0] s;
		wr_reg(`ULF_OFS_DATA, 32'hFF);
		// second byte waits in the holding register until the flush
		wr_reg(`ULF_OFS_DATA, 32'h0F);
		wr_reg(`ULF_OFS_QCTL, 32'h04);
		rd_reg(`ULF_OFS_QCTL, s);
		chk(s, 32'h04);
		rd_reg(`ULF_OFS_QCTL, s);
		chk(s, 32'h0);
		rd_reg(`ULF_OFS_STAT, s);
		chk(s & 32'h3, 32'h0);
		chk({31'h0, txd}, 32'h1);
		$display("flush test done");
	endtask : t_flush
	// ==========================================
	// main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		foreach (lcs[i])
			t_frame(lcs[i], 8'hC5 ^ 8'(i));
		t_break();
		t_rx(7'h1B, 2'h0);
		t_rx(7'h0B, 2'h1);
		t_rx(7'h2B, 2'h1);
		t_rx(7'h13, 2'h0);
		t_rx(7'h03, 2'h2);
		t_flush();
		final_report();
	end
endmodule : ulf_line_format_tb
